// >>> rtl/rip_pkg.sv
// Package of constants and carrier types for the reset, intrusion and power-up controller.
package rip_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ          = 40_000_000;
    localparam int CLK_PER_MS      = CLK_HZ / 1000;
    localparam int POR_HOLD_MS     = 180;
    localparam int POR_HOLD_CYC    = POR_HOLD_MS * CLK_PER_MS;
    localparam int HW_RST_MIN_US   = 800;
    localparam int HW_RST_MIN_CYC  = (HW_RST_MIN_US * (CLK_HZ / 1_000_000) > 0) ?
                                     HW_RST_MIN_US * (CLK_HZ / 1_000_000) : 1;
    localparam int FAN_TIMEOUT_MS  = 4600;
    localparam int FAN_TIMEOUT_CYC = FAN_TIMEOUT_MS * CLK_PER_MS;

    // ------------------------------------------------------------------
    // Register addresses, defaults and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CFG0      = 8'h00;
    localparam logic [7:0] ADDR_CFG1      = 8'h01;
    localparam logic [7:0] ADDR_CFG3      = 8'h03;
    localparam logic [7:0] ADDR_BATT_LIM  = 8'h75;
    localparam logic [7:0] ADDR_RST_KEY   = 8'h7B;
    localparam logic [7:0] ADDR_BATT_MEAS = 8'h93;
    localparam logic [7:0] ADDR_DIG_STAT  = 8'hBE;

    localparam logic [7:0] CFG0_DEFAULT     = 8'h20;
    localparam logic [7:0] CFG1_DEFAULT     = 8'h81;
    localparam logic [7:0] CFG3_DEFAULT     = 8'h00;
    localparam logic [7:0] BATT_LIM_DEFAULT = 8'h80;
    localparam logic [7:0] RST_KEY_DEFAULT  = 8'h00;
    localparam logic [7:0] RST_KEY_VALUE    = 8'h6D;

    localparam int CFG0_SW_RESET_BIT  = 7;
    localparam int CFG1_LOCK_BIT      = 6;
    localparam int CFG1_SETUP_BIT     = 5;
    localparam int CFG3_XOR_BIT       = 6;
    localparam int CFG3_INTR_CLR_BIT  = 5;
    localparam int DIG_STAT_INTR_BIT  = 7;

    localparam int TREE_WIDTH_DEFAULT = 8;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } rip_reg_wr_s;

    typedef struct packed {
        logic diode;
        logic main_rail;
        logic battery;
        logic other;
    } rip_mon_en_s;

    typedef enum logic [1:0] {
        SEQ_HOLD = 2'b00,
        SEQ_RUN  = 2'b01,
        SEQ_EXT  = 2'b10
    } rip_seq_e;

endpackage : rip_pkg

// >>> rtl/rip_sync.sv
// Three-stage pin synchroniser whose output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module rip_sync #(
    parameter int          WIDTH     = 1,
    parameter logic [0:0]  RESET_VAL = 1'b0
) (
    input  wire logic             CLOCK,
    input  wire logic             RST,
    input  wire logic [WIDTH-1:0] PIN_IN,
    output logic      [WIDTH-1:0] PIN_OUT
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_next;

    // Each bit moves only when the last two stages agree, filtering a late settle.
    assign out_next = (s2_reg & s3_reg) | (PIN_OUT & (s2_reg | s3_reg));

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            s1_reg  <= {WIDTH{RESET_VAL}};
            s2_reg  <= {WIDTH{RESET_VAL}};
            s3_reg  <= {WIDTH{RESET_VAL}};
            PIN_OUT <= {WIDTH{RESET_VAL}};
        end
        else
        begin
            s1_reg  <= PIN_IN;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            PIN_OUT <= out_next;
        end
    end

endmodule // rip_sync

`default_nettype wire

// >>> rtl/rip_ctrl.sv
// Reset line, keyed software reset, chassis intrusion latch, power-up sequencing and board test output.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Hold reset line low 180 ms after power-on.
// - Power-on reset loads every register default.
// - Hardware reset restores subset; locked registers kept.
// - Writing bit 7 of 0x00 triggers software reset; code acts only with 0x6D in key register 0x7B and lock bit clear.
// - Software reset returns key register to default.
// - Software and hardware reset restore same set.
// - Intrusion high sets status bit, raises interrupt.
// - Intrusion flag held until clear bit written.
// - Intrusion clear bit stays until written zero.
// - Intrusion disabled while battery below lower limit.
// - Intrusion latched unpowered; interrupt waits main power.
// - Only diode, rail, battery monitored before setup.
// - Battery below limit at power-up disables intrusion.
// - Dedicated fan off; full after 4.6 s silence.
// - Shared fan drives undriven at power-up.
// - Quiet start counter enabled after main rail on.
// - Bit 6 of 0x03 enters tree test mode.
module rip_ctrl
    import rip_pkg::*;
#(
    parameter int TREE_WIDTH    = TREE_WIDTH_DEFAULT,
    parameter int POR_HOLD      = POR_HOLD_CYC,
    parameter int HW_RST_MIN    = HW_RST_MIN_CYC,
    parameter int FAN_TIMEOUT   = FAN_TIMEOUT_CYC
) (
    input  wire logic                  CLOCK,
    input  wire logic                  RST,
    input  wire logic                  RESET_LINE_N_I,
    output logic                       RESET_LINE_N_O,
    output logic                       RESET_LINE_OE,
    input  wire rip_reg_wr_s           REG_WR,
    input  wire logic                  SMB_ACTIVITY,
    input  wire logic [7:0]            BATT_MEASURE,
    input  wire logic                  CHASSIS_INTRUSION,
    input  wire logic                  MAIN_RAIL_INPUT,
    input  wire logic                  DED_FAN_PROGRAMMED,
    input  wire logic [2:0]            SHARED_FAN_PROGRAMMED,
    input  wire logic [TREE_WIDTH-1:0] TREE_INPUTS,
    output logic [7:0]                 CFG0,
    output logic [7:0]                 CFG1,
    output logic [7:0]                 CFG3,
    output logic [7:0]                 BATT_LIMIT,
    output logic [7:0]                 RESET_KEY,
    output logic [7:0]                 DIG_STATUS,
    output logic                       INTRUSION_IRQ,
    output logic                       INTRUSION_ENABLED,
    output rip_mon_en_s                MON_ENABLE,
    output logic                       QUIET_START_EN,
    output logic                       DEDICATED_FAN_DRIVE,
    output logic [2:0]                 SHARED_FAN_DRIVE_O,
    output logic [2:0]                 SHARED_FAN_DRIVE_OE,
    output logic                       DEVICE_RESET,
    output logic                       XOR_TEST_O,
    output logic                       XOR_TEST_OE
);

    // ------------------------------------------------------------------
    // Widths and helpers
    // ------------------------------------------------------------------
    localparam int POR_W = $clog2(POR_HOLD + 1);
    localparam int HWR_W = $clog2(HW_RST_MIN + 1);
    localparam int FAN_W = $clog2(FAN_TIMEOUT + 1);
    localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_HOLD - 1);
    localparam logic [HWR_W-1:0] HWR_LAST = HWR_W'(HW_RST_MIN - 1);
    localparam logic [FAN_W-1:0] FAN_LAST = FAN_W'(FAN_TIMEOUT - 1);

    function automatic logic reg_hit(input rip_reg_wr_s w, input logic [7:0] a);
        reg_hit = w.wr && (w.addr == a);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic                  line_n_sync;
    logic                  intrusion_sync;
    logic                  rail_sync;
    logic [TREE_WIDTH-1:0] tree_sync;

    rip_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_line (
        .CLOCK   (CLOCK),
        .RST     (RST),
        .PIN_IN  (RESET_LINE_N_I),
        .PIN_OUT (line_n_sync)
    );

    rip_sync #(.WIDTH(2), .RESET_VAL(1'b0)) u_sync_misc (
        .CLOCK   (CLOCK),
        .RST     (RST),
        .PIN_IN  ({CHASSIS_INTRUSION, MAIN_RAIL_INPUT}),
        .PIN_OUT ({intrusion_sync, rail_sync})
    );

    rip_sync #(.WIDTH(TREE_WIDTH), .RESET_VAL(1'b0)) u_sync_tree (
        .CLOCK   (CLOCK),
        .RST     (RST),
        .PIN_IN  (TREE_INPUTS),
        .PIN_OUT (tree_sync)
    );

    // ------------------------------------------------------------------
    // Reset line sequencer
    // ------------------------------------------------------------------
    rip_seq_e         seq_reg;
    rip_seq_e         seq_next;
    logic [POR_W-1:0] por_cnt_reg;
    logic [HWR_W-1:0] hwr_cnt_reg;
    logic             hw_reset_pulse;
    logic             por_done;
    logic             hwr_done;

    assign por_done = (por_cnt_reg == POR_LAST);
    assign hwr_done = (hwr_cnt_reg == HWR_LAST);
    // A low line only counts once our own power-on drive has been released.
    assign hw_reset_pulse = (seq_reg == SEQ_EXT) && hwr_done && !line_n_sync;

    always_comb
    begin
        seq_next = seq_reg;
        unique case (seq_reg)
            SEQ_HOLD: if (por_done) seq_next = SEQ_RUN;
            SEQ_RUN:  if (!line_n_sync) seq_next = SEQ_EXT;
            SEQ_EXT:  if (line_n_sync) seq_next = SEQ_RUN;
            default:  seq_next = SEQ_HOLD;
        endcase
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            seq_reg     <= SEQ_HOLD;
            por_cnt_reg <= '0;
            hwr_cnt_reg <= '0;
        end
        else
        begin
            seq_reg <= seq_next;
            if (seq_reg == SEQ_HOLD && !por_done)
                por_cnt_reg <= por_cnt_reg + POR_W'(1);
            if (seq_reg == SEQ_EXT && !line_n_sync)
            begin
                if (hwr_cnt_reg <= HWR_LAST)
                    hwr_cnt_reg <= hwr_cnt_reg + HWR_W'(1);
            end
            else
                hwr_cnt_reg <= '0;
        end
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            RESET_LINE_N_O <= 1'b0;
            RESET_LINE_OE  <= 1'b1;
        end
        else
        begin
            RESET_LINE_N_O <= 1'b0;
            RESET_LINE_OE  <= (seq_next == SEQ_HOLD);
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers and keyed software reset
    // ------------------------------------------------------------------
    logic       locked;
    logic       wr_cfg0;
    logic       wr_cfg1;
    logic       wr_cfg3;
    logic       sw_reset_pulse;
    logic       partial_reset;
    logic [7:0] cfg0_next;
    logic [7:0] cfg1_next;
    logic [7:0] cfg3_next;
    logic [7:0] key_next;
    logic [7:0] lim_next;

    assign locked  = CFG1[CFG1_LOCK_BIT];
    assign wr_cfg0 = reg_hit(REG_WR, ADDR_CFG0) && !locked;
    assign wr_cfg1 = reg_hit(REG_WR, ADDR_CFG1) && !locked;
    assign wr_cfg3 = reg_hit(REG_WR, ADDR_CFG3) && !locked;
    // Without the key in place the reset bit is dropped, so a stray write cannot reset the part.
    assign sw_reset_pulse = wr_cfg0 && REG_WR.data[CFG0_SW_RESET_BIT]
                            && (RESET_KEY == RST_KEY_VALUE);
    // Both reset sources share one restore path, so the restored set is identical.
    assign partial_reset  = sw_reset_pulse || hw_reset_pulse;

    // The reset bit reads back zero; it acts only as a trigger.
    assign cfg0_next = partial_reset ? (locked ? CFG0 : CFG0_DEFAULT) :
                       wr_cfg0 ? (REG_WR.data & ~(8'h01 << CFG0_SW_RESET_BIT)) : CFG0;
    // Lock is sticky until a power-on reset.
    assign cfg1_next = partial_reset ? (locked ? CFG1 : CFG1_DEFAULT) :
                       wr_cfg1 ? REG_WR.data : CFG1;
    // The intrusion clear bit is held as written and never self-clears.
    assign cfg3_next = partial_reset ? (locked ? CFG3 : CFG3_DEFAULT) :
                       wr_cfg3 ? REG_WR.data : CFG3;
    assign key_next  = partial_reset ? RST_KEY_DEFAULT :
                       reg_hit(REG_WR, ADDR_RST_KEY) ? REG_WR.data : RESET_KEY;
    // The battery limit is a limit register that only power-on restores.
    assign lim_next  = reg_hit(REG_WR, ADDR_BATT_LIM) ? REG_WR.data : BATT_LIMIT;

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            CFG0         <= CFG0_DEFAULT;
            CFG1         <= CFG1_DEFAULT;
            CFG3         <= CFG3_DEFAULT;
            RESET_KEY    <= RST_KEY_DEFAULT;
            BATT_LIMIT   <= BATT_LIM_DEFAULT;
            DEVICE_RESET <= 1'b0;
        end
        else
        begin
            CFG0         <= cfg0_next;
            CFG1         <= cfg1_next;
            CFG3         <= cfg3_next;
            RESET_KEY    <= key_next;
            BATT_LIMIT   <= lim_next;
            DEVICE_RESET <= partial_reset;
        end
    end

    // ------------------------------------------------------------------
    // Chassis intrusion
    // ------------------------------------------------------------------
    logic batt_ok;
    logic intr_flag;
    logic intr_next;

    assign batt_ok   = !(BATT_MEASURE < BATT_LIMIT);
    assign intr_flag = DIG_STATUS[DIG_STAT_INTR_BIT];
    // A new event wins over a clear in the same cycle.
    assign intr_next = (batt_ok && intrusion_sync) ? 1'b1 :
                       CFG3[CFG3_INTR_CLR_BIT] ? 1'b0 : intr_flag;

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            DIG_STATUS        <= 8'h00;
            INTRUSION_IRQ     <= 1'b0;
            INTRUSION_ENABLED <= 1'b0;
        end
        else
        begin
            DIG_STATUS        <= {intr_next, DIG_STATUS[DIG_STAT_INTR_BIT-1:0]};
            // The latch keeps its event while the rail is down; the request waits for it.
            INTRUSION_IRQ     <= intr_next && rail_sync;
            INTRUSION_ENABLED <= batt_ok;
        end
    end

    // ------------------------------------------------------------------
    // Power-up monitoring and fan drives
    // ------------------------------------------------------------------
    logic             setup_done;
    logic             smb_seen_reg;
    logic             fan_full_reg;
    logic [FAN_W-1:0] fan_cnt_reg;
    logic             fan_timeout;

    assign setup_done  = CFG1[CFG1_SETUP_BIT];
    assign fan_timeout = rail_sync && !smb_seen_reg && !fan_full_reg && (fan_cnt_reg == FAN_LAST);

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            smb_seen_reg <= 1'b0;
            fan_full_reg <= 1'b0;
            fan_cnt_reg  <= '0;
        end
        else
        begin
            if (SMB_ACTIVITY || REG_WR.wr)
                smb_seen_reg <= 1'b1;
            if (fan_timeout)
                fan_full_reg <= 1'b1;
            if (rail_sync && !smb_seen_reg && !fan_full_reg && !fan_timeout)
                fan_cnt_reg <= fan_cnt_reg + FAN_W'(1);
        end
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            MON_ENABLE          <= '0;
            QUIET_START_EN      <= 1'b0;
            DEDICATED_FAN_DRIVE <= 1'b0;
            SHARED_FAN_DRIVE_O  <= 3'h0;
            SHARED_FAN_DRIVE_OE <= 3'h0;
        end
        else
        begin
            MON_ENABLE.diode     <= 1'b1;
            MON_ENABLE.main_rail <= 1'b1;
            MON_ENABLE.battery   <= 1'b1;
            MON_ENABLE.other     <= setup_done;
            QUIET_START_EN       <= rail_sync;
            DEDICATED_FAN_DRIVE  <= fan_full_reg || (smb_seen_reg && DED_FAN_PROGRAMMED);
            // Until setup the shared pins stay released and float high.
            SHARED_FAN_DRIVE_O   <= 3'h0;
            SHARED_FAN_DRIVE_OE  <= setup_done ? ~SHARED_FAN_PROGRAMMED : 3'h0;
        end
    end

    // ------------------------------------------------------------------
    // Board test tree
    // ------------------------------------------------------------------
    logic tree_result;

    // Inputs pass the pin synchronisers, so the output trails a toggle by five cycles.
    assign tree_result = ^tree_sync;

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            XOR_TEST_O  <= 1'b0;
            XOR_TEST_OE <= 1'b0;
        end
        else
        begin
            XOR_TEST_O  <= 1'b0;
            XOR_TEST_OE <= CFG3[CFG3_XOR_BIT] && !tree_result;
        end
    end

endmodule // rip_ctrl

`default_nettype wire

// >>> testbench/rip_ctrl_properties.sv
// Port checker of the reset controller.
`timescale 1ns/1ps
`default_nettype none

module rip_ctrl_properties
    import rip_pkg::*;
#(
    parameter int POR_HOLD    = 50,
    parameter int FAN_TIMEOUT = 100,
    parameter int TREE_WIDTH  = 8
) (
    input wire logic                  CLOCK,
    input wire logic                  RST,
    input wire logic                  RESET_LINE_N_O,
    input wire logic                  RESET_LINE_OE,
    input wire rip_reg_wr_s           REG_WR,
    input wire logic                  SMB_ACTIVITY,
    input wire logic [7:0]            BATT_MEASURE,
    input wire logic                  MAIN_RAIL_INPUT,
    input wire logic [TREE_WIDTH-1:0] TREE_INPUTS,
    input wire logic [7:0]            CFG0,
    input wire logic [7:0]            CFG1,
    input wire logic [7:0]            CFG3,
    input wire logic [7:0]            BATT_LIMIT,
    input wire logic [7:0]            RESET_KEY,
    input wire logic [7:0]            DIG_STATUS,
    input wire logic                  INTRUSION_IRQ,
    input wire logic                  QUIET_START_EN,
    input wire logic                  DEDICATED_FAN_DRIVE,
    input wire logic [2:0]            SHARED_FAN_DRIVE_OE,
    input wire logic                  DEVICE_RESET,
    input wire logic                  XOR_TEST_O,
    input wire logic                  XOR_TEST_OE
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    // --------
    // Helper counters
    // --------
    int   since_reg;
    int   rail_reg;
    logic smb_reg;

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            since_reg <= 0;
            rail_reg  <= 0;
            smb_reg   <= 1'b0;
        end
        else
        begin
            if (since_reg < POR_HOLD + 2)
                since_reg <= since_reg + 1;
            if (MAIN_RAIL_INPUT && rail_reg < FAN_TIMEOUT)
                rail_reg <= rail_reg + 1;
            if (SMB_ACTIVITY || REG_WR.wr)
                smb_reg <= 1'b1;
        end
    end

    // --------
    // Properties
    // --------
    sequence s_wr_reset;
        REG_WR.wr && REG_WR.addr == ADDR_CFG0 && REG_WR.data[CFG0_SW_RESET_BIT];
    endsequence
    sequence s_keyed;
        s_wr_reset ##0 (RESET_KEY == RST_KEY_VALUE && !CFG1[CFG1_LOCK_BIT]);
    endsequence

    a_por_line_held: assert property (since_reg < POR_HOLD - 1 |-> RESET_LINE_OE && !RESET_LINE_N_O)
        else $error("reset line released early");
    a_por_line_free: assert property (since_reg > POR_HOLD + 1 |-> !RESET_LINE_OE)
        else $error("reset line still driven");
    a_sw_reset_done: assert property (s_keyed |=> DEVICE_RESET && RESET_KEY == RST_KEY_DEFAULT
        && CFG0 == CFG0_DEFAULT && CFG3 == CFG3_DEFAULT) else $error("keyed reset not applied");
    a_sw_reset_refused: assert property (s_wr_reset ##0 RESET_KEY != RST_KEY_VALUE
        |=> !DEVICE_RESET && !CFG0[CFG0_SW_RESET_BIT]) else $error("reset without key");
    a_limit_kept: assert property (DEVICE_RESET |-> $stable(BATT_LIMIT))
        else $error("limit changed by reset");
    a_flag_held: assert property (DIG_STATUS[7] && !CFG3[5] |=> DIG_STATUS[7])
        else $error("intrusion flag lost");
    a_clear_bit_held: assert property (CFG3[5] && !(REG_WR.wr && REG_WR.addr == ADDR_CFG3)
        |=> CFG3[5] || DEVICE_RESET) else $error("clear bit dropped");
    a_irq_raised: assert property ((DIG_STATUS[7] && !CFG3[5] && MAIN_RAIL_INPUT) [*6] |=> INTRUSION_IRQ)
        else $error("no intrusion interrupt");
    a_irq_deferred: assert property (!MAIN_RAIL_INPUT [*7] |-> !INTRUSION_IRQ && !QUIET_START_EN)
        else $error("interrupt or counter without rail");
    a_batt_low_blocks: assert property ((BATT_MEASURE < BATT_LIMIT) [*4] |-> !$rose(DIG_STATUS[7]))
        else $error("intrusion latched on low battery");
    a_fan_quiet: assert property (!smb_reg && rail_reg < FAN_TIMEOUT |-> !DEDICATED_FAN_DRIVE)
        else $error("fan driven before timeout");
    a_shared_released: assert property (!CFG1[5] && !$past(CFG1[5]) |-> SHARED_FAN_DRIVE_OE == 3'h0)
        else $error("shared fan drive driven");
    a_tree_result: assert property ((CFG3[6] && $stable(TREE_INPUTS)) [*7]
        |-> XOR_TEST_OE == ~^TREE_INPUTS && !XOR_TEST_O) else $error("tree output wrong");
    a_tree_off: assert property (!CFG3[6] [*2] |-> !XOR_TEST_OE)
        else $error("tree output outside test mode");
endmodule // rip_ctrl_properties

bind rip_ctrl rip_ctrl_properties #(.POR_HOLD(POR_HOLD), .FAN_TIMEOUT(FAN_TIMEOUT), .TREE_WIDTH(TREE_WIDTH))
    u_rip_ctrl_properties (.CLOCK, .RST, .RESET_LINE_N_O, .RESET_LINE_OE, .REG_WR, .SMB_ACTIVITY,
    .BATT_MEASURE, .MAIN_RAIL_INPUT, .TREE_INPUTS, .CFG0, .CFG1, .CFG3, .BATT_LIMIT, .RESET_KEY,
    .DIG_STATUS, .INTRUSION_IRQ, .QUIET_START_EN, .DEDICATED_FAN_DRIVE, .SHARED_FAN_DRIVE_OE,
    .DEVICE_RESET, .XOR_TEST_O, .XOR_TEST_OE);

`default_nettype wire

// >>> testbench/rip_board_model.sv
// Board reset network: pulled-up wire and an external pull source.
`timescale 1ns/1ps
`default_nettype none

module rip_board_model (
    input  wire logic        clock,
    input  wire logic        dev_oe,
    input  wire logic        pull_go,
    input  wire logic [15:0] pull_len,
    output logic             line_n
);
    logic [15:0] left_reg = 16'h0000;

    always_ff @(posedge clock)
    begin
        if (pull_go)
            left_reg <= pull_len;
        else if (left_reg != 16'h0000)
            left_reg <= left_reg - 16'h0001;
    end

    assign line_n = !(dev_oe || left_reg != 16'h0000);
endmodule // rip_board_model

`default_nettype wire

// >>> testbench/rip_ctrl_bench.sv
// Self-checking bench of the reset controller.
`timescale 1ns/1ps
`default_nettype none

module rip_ctrl_bench;
    import rip_pkg::*;

    localparam int POR = 50;
    localparam int FAN = 100;

    logic        clock = 1'b0;
    logic        rst = 1'b1;
    rip_reg_wr_s reg_wr = '0;
    logic        smb = 1'b0;
    logic [7:0]  batt = 8'h90;
    logic        intr = 1'b0;
    logic        rail = 1'b1;
    logic [2:0]  sh_prog = 3'h2;
    logic [7:0]  tree = 8'h00;
    logic        pull_go = 1'b0;
    logic        line_n;
    logic        line_oe;
    logic [7:0]  cfg0, cfg1, cfg3, lim, key, stat;
    logic        irq, intr_en, quiet, fan, dev_rst, x_oe;
    logic [2:0]  sh_oe, sh_o;
    rip_mon_en_s mon;
    int          err_total = 0;
    int          n_compared = 0;
    int          n_rst = 0;
    int          t_oe = 0;
    int          t_fan = 0;
    logic [7:0]  vals [5] = '{8'h00, 8'h01, 8'h03, 8'h80, 8'hFF};

    initial
    begin
        forever #12.5 clock = ~clock;
    end

    rip_ctrl #(.POR_HOLD(POR), .HW_RST_MIN(8), .FAN_TIMEOUT(FAN)) u_rip_ctrl (
        .CLOCK(clock), .RST(rst), .RESET_LINE_N_I(line_n), .RESET_LINE_N_O(), .RESET_LINE_OE(line_oe),
        .REG_WR(reg_wr), .SMB_ACTIVITY(smb), .BATT_MEASURE(batt), .CHASSIS_INTRUSION(intr),
        .MAIN_RAIL_INPUT(rail), .DED_FAN_PROGRAMMED(1'b0), .SHARED_FAN_PROGRAMMED(sh_prog),
        .TREE_INPUTS(tree), .CFG0(cfg0), .CFG1(cfg1), .CFG3(cfg3), .BATT_LIMIT(lim), .RESET_KEY(key),
        .DIG_STATUS(stat), .INTRUSION_IRQ(irq), .INTRUSION_ENABLED(intr_en), .MON_ENABLE(mon),
        .QUIET_START_EN(quiet), .DEDICATED_FAN_DRIVE(fan), .SHARED_FAN_DRIVE_O(sh_o),
        .SHARED_FAN_DRIVE_OE(sh_oe), .DEVICE_RESET(dev_rst), .XOR_TEST_O(), .XOR_TEST_OE(x_oe));

    rip_board_model u_rip_board_model (.clock(clock), .dev_oe(line_oe), .pull_go(pull_go),
        .pull_len(16'h000E), .line_n(line_n));

    always @(posedge clock) n_rst <= n_rst + int'(dev_rst === 1'b1);

    // --------
    // Tasks
    // --------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock) reg_wr <= {1'b1, a, d};
        @(posedge clock) reg_wr.wr <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic pulse_intr();
        @(posedge clock) intr <= 1'b1;
        repeat (3) @(posedge clock);
        intr <= 1'b0;
        settle(10);
    endtask

    task automatic hw_pulse();
        @(posedge clock) pull_go <= 1'b1;
        @(posedge clock) pull_go <= 1'b0;
        settle(40);
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // --------
    // Main sequence
    // --------
    initial
    begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        for (int i = 1; i <= 200; i++)
        begin
            @(negedge clock);
            if (t_oe == 0 && line_oe === 1'b0)
                t_oe = i;
            if (t_fan == 0 && fan === 1'b1)
                t_fan = i;
        end
        chk("hold", 8'h01, {7'h00, t_oe inside {[POR - 2:POR + 2]}});
        chk("fan", 8'h01, {7'h00, t_fan inside {[FAN:FAN + 12]}});
        chk("cfg0", CFG0_DEFAULT, cfg0);
        chk("cfg1", CFG1_DEFAULT, cfg1);
        chk("cfg3", CFG3_DEFAULT, cfg3);
        chk("limit", BATT_LIM_DEFAULT, lim);
        chk("key", RST_KEY_DEFAULT, key);
        chk("shared", 8'h00, {2'h0, sh_o, sh_oe});
        chk("monitor", 8'h0E, {4'h0, mon});
        chk("quiet", 8'h01, {7'h00, quiet});
        chk("enabled", 8'h01, {7'h00, intr_en});
        $display("test power_up done");

        wr(ADDR_BATT_LIM, 8'h40);
        wr(ADDR_CFG0, 8'h80);
        settle(2);
        chk("unkeyed", 8'h00, cfg0);
        wr(ADDR_RST_KEY, RST_KEY_VALUE);
        wr(ADDR_CFG3, 8'h20);
        wr(ADDR_CFG0, 8'h80);
        settle(2);
        chk("resets", 8'h01, 8'(n_rst));
        chk("cfg0", CFG0_DEFAULT, cfg0);
        chk("cfg3", CFG3_DEFAULT, cfg3);
        chk("key", RST_KEY_DEFAULT, key);
        chk("limit", 8'h40, lim);
        wr(ADDR_CFG0, 8'h80);
        settle(2);
        chk("resets", 8'h01, 8'(n_rst));
        $display("test soft_reset done");

        pulse_intr();
        chk("status", 8'h80, stat);
        chk("irq", 8'h01, {7'h00, irq});
        wr(ADDR_CFG3, 8'h20);
        settle(8);
        chk("status", 8'h00, stat);
        chk("cfg3", 8'h20, cfg3);
        wr(ADDR_CFG3, 8'h00);
        @(posedge clock) batt <= 8'h10;
        settle(6);
        pulse_intr();
        chk("status", 8'h00, stat);
        chk("enabled", 8'h00, {7'h00, intr_en});
        @(posedge clock) batt <= 8'h90;
        rail <= 1'b0;
        settle(10);
        pulse_intr();
        chk("status", 8'h80, stat);
        chk("irq", 8'h00, {7'h00, irq});
        @(posedge clock) rail <= 1'b1;
        settle(10);
        chk("irq", 8'h01, {7'h00, irq});
        $display("test intrusion done");

        wr(ADDR_BATT_LIM, 8'h55);
        wr(ADDR_CFG3, 8'h20);
        hw_pulse();
        chk("resets", 8'h02, 8'(n_rst));
        chk("cfg3", CFG3_DEFAULT, cfg3);
        chk("limit", 8'h55, lim);
        $display("test hard_reset done");

        @(posedge clock) smb <= 1'b1;
        @(posedge clock) smb <= 1'b0;
        wr(ADDR_CFG1, 8'hA1);
        settle(8);
        chk("monitor", 8'h0F, {4'h0, mon});
        chk("shared", 8'h05, {2'h0, sh_o, sh_oe});
        wr(ADDR_CFG3, 8'h40);
        foreach (vals[i])
        begin
            @(posedge clock) tree <= vals[i];
            settle(8);
            chk("tree", {7'h00, ~^vals[i]}, {7'h00, x_oe});
        end
        wr(ADDR_CFG3, 8'h00);
        settle(3);
        chk("tree off", 8'h00, {7'h00, x_oe});
        $display("test setup_tree done");

        wr(ADDR_CFG3, 8'h40);
        wr(ADDR_CFG1, 8'hE1);
        wr(ADDR_CFG3, 8'h00);
        hw_pulse();
        chk("resets", 8'h03, 8'(n_rst));
        chk("cfg1", 8'hE1, cfg1);
        chk("cfg3", 8'h40, cfg3);
        $display("test lock done");
        test_done();
    end
endmodule // rip_ctrl_bench

`default_nettype wire
